/* core/dcfc_pkg.sv */
package dcfc_pkg;
    // ==========================================================
    // Register map.
    // Printed offsets are not multiples of four: they are indices.
    localparam logic [15:0] DCFC_IDX_HIBERNATE   = 16'hF400;
    localparam logic [15:0] DCFC_IDX_START_SEL   = 16'hF401;
    localparam int          DCFC_ADDR_W          = 18;
    // Byte address is four times the index.
    localparam logic [17:0] DCFC_ADDR_HIBERNATE  = {DCFC_IDX_HIBERNATE, 2'b00};
    localparam logic [17:0] DCFC_ADDR_START_SEL  = {DCFC_IDX_START_SEL, 2'b00};
    // Software-visible status register at an index of our choosing.
    localparam logic [15:0] DCFC_IDX_STATUS      = 16'hF4F0;
    localparam logic [17:0] DCFC_ADDR_STATUS     = {DCFC_IDX_STATUS, 2'b00};

    // ==========================================================
    // Reset values and field layout.
    localparam logic [15:0] DCFC_HIB_RESET       = 16'h0000;
    localparam logic [15:0] DCFC_SEL_RESET       = 16'h0002;
    localparam int          DCFC_HIB_BIT         = 0;
    localparam int          DCFC_SEL_W           = 5;

    // ==========================================================
    // Frame start selector codes.
    localparam logic [4:0] DCFC_SEL_CG1_DIV4     = 5'h00;
    localparam logic [4:0] DCFC_SEL_CG1_X4       = 5'h04;
    localparam logic [4:0] DCFC_SEL_CG2_DIV6     = 5'h05;
    localparam logic [4:0] DCFC_SEL_CG2_2DIV3    = 5'h07;
    localparam logic [4:0] DCFC_SEL_SIN0         = 5'h08;
    localparam logic [4:0] DCFC_SEL_SIN3         = 5'h0B;
    localparam logic [4:0] DCFC_SEL_SOUT0        = 5'h0C;
    localparam logic [4:0] DCFC_SEL_SOUT3        = 5'h0F;
    localparam logic [4:0] DCFC_SEL_SPDIF        = 5'h10;

    // ==========================================================
    // Core power states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        DCFC_RUN       = 2'b00,
        DCFC_DRAIN     = 2'b01,
        DCFC_HIBERNATE = 2'b11,
        DCFC_WAKE      = 2'b10
    } dcfc_state_t;
endpackage : dcfc_pkg

/* core/dcfc_pulse_sel.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Frame start selector: synchronises the pin-sourced frame
// clocks and turns the chosen source into a one-cycle pulse.
module dcfc_pulse_sel (
    input  wire logic        mclk,        // System clock.
    input  wire logic        rst,         // Asynchronous reset, active high.
    input  wire logic [4:0]  sel,         // Frame start selector code.
    input  wire logic [4:0]  cg1_pulse,   // Clock generator 1 pulses, div4..x4.
    input  wire logic [2:0]  cg2_pulse,   // Clock generator 2 pulses, div6, div3, 2/3.
    input  wire logic [3:0]  sin_lrclk,   // Serial input port frame clock pins.
    input  wire logic [3:0]  sout_lrclk,  // Serial output port frame clock pins.
    input  wire logic        spdif_pulse, // S/PDIF receiver rate pulse.
    output logic             frame_start  // One-cycle frame start pulse.
);
    import dcfc_pkg::*;

    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] lvl_q;
    logic [7:0] pin_edge;
    logic       pick;

    // Three-stage synchroniser for the pin frame clocks.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
        end else begin
            s1_q <= {sout_lrclk, sin_lrclk};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Confirmed pin levels: a level counts only once stages two and three
    // agree, so a single metastable sample cannot make a frame pulse.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lvl_q <= 8'h00;
        end else begin
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end

    // A rising frame clock gives one pulse, on the cycle it is confirmed.
    assign pin_edge = s2_q & s3_q & ~lvl_q;

    // Source decode; reserved codes give no pulse.
    always_comb begin
        pick = 1'b0;
        if (sel <= DCFC_SEL_CG1_X4) begin
            pick = cg1_pulse[sel[2:0]];
        end else if (sel <= DCFC_SEL_CG2_2DIV3) begin
            pick = cg2_pulse[2'(sel - DCFC_SEL_CG2_DIV6)];
        end else if (sel <= DCFC_SEL_SIN3) begin
            pick = pin_edge[sel[1:0]];
        end else if (sel <= DCFC_SEL_SOUT3) begin
            pick = pin_edge[{1'b1, sel[1:0]}];
        end else if (sel == DCFC_SEL_SPDIF) begin
            pick = spdif_pulse;
        end
    end

    // Registered pulse output.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_start <= 1'b0;
        end else begin
            frame_start <= pick;
        end
    end
endmodule // dcfc_pulse_sel
`default_nettype wire

/* core/dcfc_top.sv */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Frame control register bank for the audio core.
module dcfc_top (
    input  wire logic        mclk,            // System clock, 250 MHz.
    input  wire logic        rst,             // Asynchronous reset, active high.
    input  wire logic [17:0] avs_address,     // Avalon byte address.
    input  wire logic        avs_read,        // Avalon read request.
    input  wire logic        avs_write,       // Avalon write request.
    input  wire logic [31:0] avs_writedata,   // Avalon write data.
    input  wire logic [3:0]  avs_byteenable,  // Avalon byte enables.
    output logic [31:0]      avs_readdata,    // Avalon read data.
    output logic             avs_waitrequest, // Avalon wait request.
    output logic [1:0]       avs_response,    // Avalon response, 2 = slave error.
    input  wire logic [4:0]  cg1_pulse,       // Clock generator 1 rate pulses.
    input  wire logic [2:0]  cg2_pulse,       // Clock generator 2 rate pulses.
    input  wire logic [3:0]  sin_lrclk,       // Serial input frame clock pins.
    input  wire logic [3:0]  sout_lrclk,      // Serial output frame clock pins.
    input  wire logic        spdif_pulse,     // S/PDIF receiver rate pulse.
    input  wire logic        block_busy,      // Core is mid-way through a block.
    input  wire logic [7:0]  core_irq_in,     // Incoming core interrupts.
    output logic [7:0]       core_irq_out,    // Interrupts passed to the core.
    output logic             frame_start,     // Selected frame start pulse.
    output logic             core_hibernating // Core held in low-power idle.
);
    import dcfc_pkg::*;

    // ==========================================================
    // Registers and state.
    logic [15:0] hib_q;
    logic [15:0] sel_q;
    dcfc_state_t state_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [1:0]  resp_q;
    logic        req;
    logic        hit_hib;
    logic        hit_sel;
    logic        hit_stat;
    logic        irq_mask;

    // Merges byte-enabled write data into a 16-bit register.
    // Lanes 2 and 3 carry nothing: both registers sit in bits 15:0.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = old;
        if (be[0]) merge16[7:0]  = wd[7:0];
        if (be[1]) merge16[15:8] = wd[15:8];
    endfunction

    // True for the three addresses that this slave answers without error.
    function automatic logic is_mapped(input logic [17:0] addr);
        is_mapped = (addr == DCFC_ADDR_HIBERNATE) ||
                    (addr == DCFC_ADDR_START_SEL) ||
                    (addr == DCFC_ADDR_STATUS);
    endfunction

    // ==========================================================
    // Avalon slave: one wait cycle, answer on the second.
    // The wait request is combinational so that the first cycle of every
    // request stalls; the acknowledge flop then opens exactly one edge.
    // The response and read data are captured in that stall cycle, so a master
    // that changed its address while waiting would see stale data.
    // Unmapped addresses still complete, with a slave error response.
    assign req      = (avs_read | avs_write) & ~ack_q;
    assign hit_hib  = (avs_address == DCFC_ADDR_HIBERNATE);
    assign hit_sel  = (avs_address == DCFC_ADDR_START_SEL);
    assign hit_stat = (avs_address == DCFC_ADDR_STATUS);
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata    = rdata_q;
    assign avs_response    = resp_q;

    // Acknowledge flag drops the wait request for exactly one edge.
    // A master that holds its request past it starts a new transfer.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Register writes take effect on the acknowledging edge.
    // Only that edge writes, so a stalled request never writes twice.
    // Lanes above bit 15 are dropped; the registers are 16 bits wide.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hib_q <= DCFC_HIB_RESET;
            sel_q <= DCFC_SEL_RESET;
        end else if (ack_q && avs_write) begin
            // Upper bits are stored and otherwise unused.
            if (hit_hib) hib_q <= merge16(hib_q, avs_writedata, avs_byteenable);
            if (hit_sel) sel_q <= merge16(sel_q, avs_writedata, avs_byteenable);
        end
    end

    // Read data and response are prepared during the wait cycle.
    // The status register shows the power state; writes to it are dropped.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
            resp_q  <= 2'h0;
        end else if (req) begin
            resp_q  <= is_mapped(avs_address) ? 2'h0 : 2'h2;
            rdata_q <= 32'h0000_0000;
            if (avs_read && hit_hib)  rdata_q <= {16'h0000, hib_q};
            if (avs_read && hit_sel)  rdata_q <= {16'h0000, sel_q};
            if (avs_read && hit_stat) rdata_q <= {30'h0, state_q};
        end
    end

    // ==========================================================
    // Frame start source selection.
    // Generator and receiver pulses share the system clock and pass
    // straight through; pin frame clocks come from outside and are
    // synchronised first, which costs a few cycles of latency.
    // Reserved codes select nothing, so the core simply sees no frames.
    dcfc_pulse_sel dcfc_pulse_sel_inst (
        .mclk        (mclk),
        .rst         (rst),
        .sel         (sel_q[DCFC_SEL_W-1:0]),
        .cg1_pulse   (cg1_pulse),
        .cg2_pulse   (cg2_pulse),
        .sin_lrclk   (sin_lrclk),
        .sout_lrclk  (sout_lrclk),
        .spdif_pulse (spdif_pulse),
        .frame_start (frame_start)
    );

    // ==========================================================
    // Hibernation sequencing; entering HIBERNATE from DRAIN and leaving WAKE for RUN wait for a frame pulse.
    // The sequence is RUN, DRAIN, HIBERNATE, WAKE and back to RUN, with one
    // bit changing per step. DRAIN lets the running sample or block finish:
    // a frame pulse marks the sample boundary and a low block_busy marks the
    // block boundary. WAKE keeps interrupts masked until the next frame, so
    // the core never restarts part-way through a sample.
    // A request seen again during WAKE returns straight to hibernation.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= DCFC_RUN;
        end else begin
            case (state_q)
                DCFC_RUN: begin
                    if (hib_q[DCFC_HIB_BIT]) state_q <= DCFC_DRAIN;
                end
                DCFC_DRAIN: begin
                    // Enter only at a frame edge with no block in flight.
                    if (!hib_q[DCFC_HIB_BIT]) begin
                        state_q <= DCFC_RUN;
                    end else if (frame_start && !block_busy) begin
                        state_q <= DCFC_HIBERNATE;
                    end
                end
                DCFC_HIBERNATE: begin
                    if (!hib_q[DCFC_HIB_BIT]) state_q <= DCFC_WAKE;
                end
                DCFC_WAKE: begin
                    if (hib_q[DCFC_HIB_BIT]) begin
                        state_q <= DCFC_HIBERNATE;
                    end else if (frame_start) begin
                        state_q <= DCFC_RUN;
                    end
                end
                default: state_q <= DCFC_RUN;
            endcase
        end
    end

    // Interrupts are masked whenever the core sits in hibernation.
    // The gate is registered so the core never sees a glitch on a mask change.
    // The cost is one cycle of latency on every interrupt.
    assign irq_mask = (state_q == DCFC_HIBERNATE) || (state_q == DCFC_WAKE);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            core_irq_out     <= 8'h00;
            core_hibernating <= 1'b0;
        end else begin
            core_irq_out     <= irq_mask ? 8'h00 : core_irq_in;
            core_hibernating <= irq_mask;
        end
    end

    // ==========================================================
    // Assertions.
    // The checks watch the bus answer, the register contents, the frame
    // source decode and the hibernation sequence. Each label line names
    // the rule that it guards.
    a_hib_waits_frame: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_DRAIN) ##1 (state_q == DCFC_HIBERNATE)
        |-> $past(frame_start) && !$past(block_busy))
        else $error("Hibernation entered outside a frame edge.");
    a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_HIBERNATE) ##1 (state_q == DCFC_HIBERNATE)
        |-> core_irq_out == 8'h00)
        else $error("Interrupt passed while hibernating.");
    a_irq_passes: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_RUN) ##1 (state_q == DCFC_RUN)
        |-> core_irq_out == $past(core_irq_in))
        else $error("Interrupt lost in normal operation.");
    a_run_to_drain: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_RUN) && hib_q[0] |=> state_q == DCFC_DRAIN)
        else $error("Hibernate request not seen.");
    a_wake_frame: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_WAKE) && !hib_q[0] && frame_start |=> state_q == DCFC_RUN)
        else $error("Wake did not follow the frame pulse.");
    a_spdif_sel: assert property (@(posedge mclk) disable iff (rst)
        (sel_q[4:0] == DCFC_SEL_SPDIF) && $stable(sel_q) && spdif_pulse |=> frame_start)
        else $error("S/PDIF pulse not forwarded.");
    a_cg1_sel: assert property (@(posedge mclk) disable iff (rst)
        (sel_q[4:0] == 5'h02) && $stable(sel_q) |=> frame_start == $past(cg1_pulse[2]))
        else $error("Base rate pulse not forwarded.");
    a_reserved_sel: assert property (@(posedge mclk) disable iff (rst)
        (sel_q[4:0] > DCFC_SEL_SPDIF) && $stable(sel_q) |=> !frame_start)
        else $error("Reserved code produced a pulse.");
    a_bus_answer: assert property (@(posedge mclk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus answer late.");

    // Register reset values, read-back and refused addresses.
    a_reset_values: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> (hib_q == DCFC_HIB_RESET) && (sel_q == DCFC_SEL_RESET))
        else $error("Registers left reset with wrong values.");
    a_hib_readback: assert property (@(posedge mclk) disable iff (rst)
        avs_read && !avs_waitrequest && hit_hib |-> avs_readdata == {16'h0000, hib_q})
        else $error("Hibernate register read back wrong.");
    a_sel_readback: assert property (@(posedge mclk) disable iff (rst)
        avs_read && !avs_waitrequest && hit_sel |-> avs_readdata == {16'h0000, sel_q})
        else $error("Selector register read back wrong.");
    a_bad_address: assert property (@(posedge mclk) disable iff (rst)
        (avs_read || avs_write) && !avs_waitrequest && !is_mapped(avs_address)
        |-> avs_response == 2'h2)
        else $error("Unmapped address answered without error.");

    // Hibernation sequence.
    a_drain_waits: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_DRAIN) && hib_q[0] && !(frame_start && !block_busy)
        |=> state_q == DCFC_DRAIN)
        else $error("Hibernation entered before the sample or block ended.");
    a_drain_cancel: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_DRAIN) && !hib_q[0] |=> state_q == DCFC_RUN)
        else $error("Cleared request did not return to normal operation.");
    a_run_stays: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_RUN) && !hib_q[0] |=> state_q == DCFC_RUN)
        else $error("Core left normal operation without a request.");
    a_hib_holds: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_HIBERNATE) && hib_q[0] |=> state_q == DCFC_HIBERNATE)
        else $error("Hibernation left while still requested.");
    a_hib_flag: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_HIBERNATE) |=> core_hibernating && (core_irq_out == 8'h00))
        else $error("Hibernation not shown or interrupts not masked.");
    a_wake_masked: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_WAKE) |=> core_hibernating && (core_irq_out == 8'h00))
        else $error("Interrupt passed before the wake frame.");
    a_wake_waits: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_WAKE) && !hib_q[0] && !frame_start |=> state_q == DCFC_WAKE)
        else $error("Wake finished without a frame pulse.");
    a_wake_rehib: assert property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_WAKE) && hib_q[0] |=> state_q == DCFC_HIBERNATE)
        else $error("New request during wake not honoured.");

    // Second generator decode.
    a_cg2_sel: assert property (@(posedge mclk) disable iff (rst)
        (sel_q[4:0] == DCFC_SEL_CG2_DIV6) && $stable(sel_q)
        |=> frame_start == $past(cg2_pulse[0]))
        else $error("Second generator pulse not forwarded.");

    c_hibernate: cover property (@(posedge mclk) disable iff (rst)
        state_q == DCFC_HIBERNATE);
    c_wake: cover property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_WAKE) ##1 (state_q == DCFC_RUN));
    c_pin_pulse: cover property (@(posedge mclk) disable iff (rst)
        (sel_q[4:0] == DCFC_SEL_SIN0) && frame_start);
    c_block_wait: cover property (@(posedge mclk) disable iff (rst)
        (state_q == DCFC_DRAIN) && frame_start && block_busy);
    c_slave_error: cover property (@(posedge mclk) disable iff (rst)
        (avs_read || avs_write) && !avs_waitrequest && (avs_response == 2'h2));
endmodule // dcfc_top
`default_nettype wire

/* sim/dcfc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the frame control register bank.
module dcfc_top_tb;
    import dcfc_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [17:0] avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [4:0]  cg1_pulse = '0;
    logic [2:0]  cg2_pulse = '0;
    logic [3:0]  sin_lrclk = '0;
    logic [3:0]  sout_lrclk = '0;
    logic        spdif_pulse = 1'b0;
    logic        block_busy = 1'b0;
    logic [7:0]  core_irq_in = '0;
    logic [7:0]  core_irq_out;
    logic        frame_start;
    logic        core_hibernating;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          n;

    // Clock at 250 MHz.
    always #2 mclk = ~mclk;

    dcfc_top dcfc_top_inst (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .cg1_pulse(cg1_pulse), .cg2_pulse(cg2_pulse), .sin_lrclk(sin_lrclk),
        .sout_lrclk(sout_lrclk), .spdif_pulse(spdif_pulse), .block_busy(block_busy),
        .core_irq_in(core_irq_in), .core_irq_out(core_irq_out),
        .frame_start(frame_start), .core_hibernating(core_hibernating));

    // ==========================================================
    // Shared helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; the request holds until waitrequest is seen low.
    task automatic bus_xfer(input logic wr, input logic [17:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 64);
        if (t >= 64) check(1, 0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Fires one frame source and counts frame pulses that follow.
    task automatic fire(input int c, output int cnt);
        cnt = 0;
        @(posedge mclk);
        if (c < 5) cg1_pulse[c] <= 1'b1; // Same clock as the frame logic.
        else if (c < 8) cg2_pulse[c-5] <= 1'b1;
        else if (c < 12) sin_lrclk[c-8] <= 1'b1;
        else if (c < 16) sout_lrclk[c-12] <= 1'b1;
        else spdif_pulse <= 1'b1;
        repeat (9) begin
            @(posedge mclk);
            cg1_pulse <= '0;
            cg2_pulse <= '0;
            spdif_pulse <= 1'b0;
            #1;
            if (frame_start === 1'b1) cnt++;
        end
        @(posedge mclk);
        sin_lrclk <= '0;
        sout_lrclk <= '0;
        repeat (5) @(posedge mclk);
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reset_and_map();
        bus_xfer(0, DCFC_ADDR_HIBERNATE, 0); check(rd, 32'h0000_0000);
        bus_xfer(0, DCFC_ADDR_START_SEL, 0); check(rd, 32'h0000_0002);
        bus_xfer(0, 18'h00000, 0); check(rd, 32'h0000_0000); check(rsp, 2'h2);
    endtask

    // Every valid code selects its own source and ignores a neighbour.
    task automatic t_select_table();
        for (int c = 0; c <= 16; c++) begin
            bus_xfer(1, DCFC_ADDR_START_SEL, c);
            fire((c + 1) % 17, n); check(n, 0);
            fire(c, n); check(n, 1);
        end
    endtask

    // Reserved code and upper bits read back and give no effect.
    task automatic t_reserved();
        bus_xfer(1, DCFC_ADDR_START_SEL, 32'h0000_FFF1);
        bus_xfer(0, DCFC_ADDR_START_SEL, 0); check(rd, 32'h0000_FFF1);
        avs_byteenable <= 4'h2;
        bus_xfer(1, DCFC_ADDR_START_SEL, 32'h0000_00F2);
        avs_byteenable <= 4'hF;
        bus_xfer(0, DCFC_ADDR_START_SEL, 0); check(rd, 32'h0000_00F1);
        fire(16, n); check(n, 0);
        fire(0, n); check(n, 0);
        bus_xfer(1, DCFC_ADDR_START_SEL, 32'h0000_0002);
        bus_xfer(1, DCFC_ADDR_HIBERNATE, 32'h0000_FFFE);
        bus_xfer(0, DCFC_ADDR_HIBERNATE, 0); check(rd, 32'h0000_FFFE);
        fire(2, n); check(core_hibernating, 0);
        bus_xfer(1, DCFC_ADDR_HIBERNATE, 0);
    endtask

    // Hibernation waits for the block, masks interrupts, wakes on a frame.
    task automatic t_hibernate();
        core_irq_in <= 8'hA5;
        repeat (3) @(posedge mclk);
        check(core_irq_out, 8'hA5);
        bus_xfer(1, DCFC_ADDR_HIBERNATE, 1);
        block_busy <= 1'b1;
        bus_xfer(0, DCFC_ADDR_STATUS, 0); check(rd[1:0], 2'b01);
        fire(2, n); check({core_hibernating, core_irq_out}, {1'b0, 8'hA5});
        block_busy <= 1'b0;
        fire(2, n); check({core_hibernating, core_irq_out}, {1'b1, 8'h00});
        bus_xfer(0, DCFC_ADDR_STATUS, 0); check(rd[1:0], 2'b11);
        core_irq_in <= 8'h3C;
        bus_xfer(1, DCFC_ADDR_HIBERNATE, 0); // Clear the request; WAKE waits for the next frame.
        repeat (3) @(posedge mclk);
        check({core_hibernating, core_irq_out}, {1'b1, 8'h00});
        bus_xfer(0, DCFC_ADDR_STATUS, 0); check(rd[1:0], 2'b10);
        fire(2, n); check({core_hibernating, core_irq_out}, {1'b0, 8'h3C});
    endtask

    // ==========================================================
    // Verdict and run control.
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset_and_map();
        t_select_table();
        t_reserved();
        t_hibernate();
        wrap_up();
    end
endmodule // dcfc_top_tb
`default_nettype wire
